// [design/eec_params.svh]
`ifndef EEC_PARAMS_SVH
`define EEC_PARAMS_SVH

// line and pin counts
`define EEC_NUM_LINES    23
`define EEC_NUM_EXT      16
`define EEC_NUM_PINS     140

// register byte offsets
`define EEC_OFF_IMASK    8'h00
`define EEC_OFF_EMASK    8'h04
`define EEC_OFF_RISE     8'h08
`define EEC_OFF_FALL     8'h0c
`define EEC_OFF_PEND     8'h10
`define EEC_OFF_SEL_BASE 8'h40

// reset values
`define EEC_RST_MASK     32'h0000_0000
`define EEC_RST_EDGE     32'h0000_0000
`define EEC_RST_SEL      8'h00

// clocks from a line edge to the pending flag, worst case
`define EEC_DETECT_MAX   4

`endif

// [design/eec_pkg.sv]
`default_nettype none

package eec_pkg;
    typedef logic [7:0]  eec_addr_t;
    typedef logic [31:0] eec_word_t;
endpackage

`default_nettype wire

// [design/eec_if.sv]
`default_nettype none

// line levels toward the edge catchers, edge pulses back in clk domain
interface eec_if #(parameter int N = 23);
    logic [N-1:0] line;
    logic [N-1:0] rise_p;
    logic [N-1:0] fall_p;

    modport top (output line, input rise_p, input fall_p);
    modport det (input line, output rise_p, output fall_p);
endinterface

`default_nettype wire

// [design/eec_edge_det.sv]
`default_nettype none

module eec_edge_det #(
    parameter int N = 23
) (
    // clock and synchronised reset
    input wire logic clk,
    input wire logic rst_b,
    // lines in, pulses out
    eec_if.det       lines
);
    import eec_pkg::*;

    wire [N-1:0] rp;
    wire [N-1:0] fp;

    for (genvar g = 0; g < N; g++) begin : g_line
        logic       rise_tog;
        logic       fall_tog;
        logic [2:0] rise_sync;
        logic [2:0] fall_sync;

        // the line itself clocks a toggle, so pulses shorter than clk are kept
        always_ff @(posedge lines.line[g] or negedge rst_b) begin
            if (!rst_b)
                rise_tog <= 1'b0;
            else
                rise_tog <= ~rise_tog; // RULE_05
        end

        always_ff @(negedge lines.line[g] or negedge rst_b) begin
            if (!rst_b)
                fall_tog <= 1'b0;
            else
                fall_tog <= ~fall_tog; // RULE_05
        end

        // toggle crossing: stage 0 feeds only stage 1
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                rise_sync <= 3'h0;
                fall_sync <= 3'h0;
            end else begin
                rise_sync <= {rise_sync[1:0], rise_tog};
                fall_sync <= {fall_sync[1:0], fall_tog};
            end
        end

        // one pulse per toggle, so a short high pulse gives both edges
        assign rp[g] = rise_sync[2] ^ rise_sync[1];
        assign fp[g] = fall_sync[2] ^ fall_sync[1];
    end

    assign lines.rise_p = rp;
    assign lines.fall_p = fp;

endmodule

`default_nettype wire

// [design/eec_top.sv]
// Implementation choices: the register offsets and the strobed register port.
`include "eec_params.svh"
// Functional notes
// RULE_01: many edge lines, each raising interrupt or event
// RULE_02: per line choose rising, falling or both
// RULE_03: per line mask, independent of others
// RULE_04: per line pending status, readable by software
// RULE_05: catch pulses shorter than one clock
// RULE_06: sixteen lines sourced from any GPIO pin
// RULE_07: write one clears pending, else it stays
`default_nettype none

module eec_top #(
    parameter int NUM_LINES = `EEC_NUM_LINES,
    parameter int NUM_EXT   = `EEC_NUM_EXT,
    parameter int NUM_PINS  = `EEC_NUM_PINS,
    parameter int SEL_W     = $clog2(`EEC_NUM_PINS)
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    // line sources
    input  wire logic [NUM_PINS-1:0]          gpio_in,
    input  wire logic [NUM_LINES-NUM_EXT-1:0] int_line,
    // register port
    input  wire eec_pkg::eec_addr_t           addr,
    input  wire eec_pkg::eec_word_t           wdata,
    input  wire logic                         wr,
    input  wire logic                         rd,
    output var  eec_pkg::eec_word_t           rdata,
    // requests
    output var  logic                         irq,
    output var  logic [NUM_LINES-1:0]         evt_pulse
);
    import eec_pkg::*;

    localparam eec_addr_t SEL_BASE = `EEC_OFF_SEL_BASE;
    localparam int        DET_MAX  = `EEC_DETECT_MAX;

    // refuse shapes the register map or the select field cannot hold
    if (NUM_LINES > 32 || NUM_EXT > 16 || NUM_EXT >= NUM_LINES || NUM_PINS > 256 ||
        SEL_W < $clog2(NUM_PINS) || SEL_W > 8) begin : g_bad_cfg
        $error("eec_top: unsupported line, pin or select width");
    end

    logic                   rst_meta;
    logic                   rst_sync_b;
    logic [NUM_LINES-1:0]   imask;
    logic [NUM_LINES-1:0]   emask;
    logic [NUM_LINES-1:0]   rise_en;
    logic [NUM_LINES-1:0]   fall_en;
    logic [NUM_LINES-1:0]   pending;
    logic [NUM_LINES-1:0]   next_pending;
    logic [NUM_LINES-1:0]   trig;
    logic [NUM_LINES-1:0]   clr_vec;
    logic [SEL_W-1:0]       sel [NUM_EXT];
    logic [NUM_EXT-1:0]     ext_lvl;
    eec_word_t              rd_mux;
    eec_word_t              pend_word;
    logic                   masked_any;

    eec_if #(.N(NUM_LINES)) lif ();

    // is the address one of the pin select words
    function automatic logic is_sel(input eec_addr_t a);
        return (a >= SEL_BASE) && (a < SEL_BASE + 8'(4 * NUM_EXT)) && (a[1:0] == 2'h0);
    endfunction

    // index of a pin select word
    function automatic int sel_idx(input eec_addr_t a);
        return int'((a - SEL_BASE) >> 2);
    endfunction

    // release reset through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // pin routing; unsampled so short pulses reach the catchers
    // changing a select may itself look like an edge on that line
    always_comb begin
        for (int i = 0; i < NUM_EXT; i++) begin
            ext_lvl[i] = (int'(sel[i]) < NUM_PINS) ? gpio_in[sel[i]] : 1'b0; // RULE_06
        end
    end

    assign lif.line = {int_line, ext_lvl}; // RULE_01

    eec_edge_det #(.N(NUM_LINES)) u_det (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .lines (lif)
    );

    // edge qualification per line
    assign trig = (lif.rise_p & rise_en) | (lif.fall_p & fall_en); // RULE_02

    // write-one-to-clear; a new trigger beats a clear in the same cycle
    assign clr_vec      = (wr && addr == `EEC_OFF_PEND) ? wdata[NUM_LINES-1:0] : '0;
    assign next_pending = (pending & ~clr_vec) | trig; // RULE_07

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b)
            pending <= '0;
        else
            pending <= next_pending; // RULE_04
    end

    // mask and edge control registers
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            imask   <= NUM_LINES'(`EEC_RST_MASK);
            emask   <= NUM_LINES'(`EEC_RST_MASK);
            rise_en <= NUM_LINES'(`EEC_RST_EDGE);
            fall_en <= NUM_LINES'(`EEC_RST_EDGE);
        end else if (wr) begin
            case (addr)
                `EEC_OFF_IMASK: imask   <= wdata[NUM_LINES-1:0];
                `EEC_OFF_EMASK: emask   <= wdata[NUM_LINES-1:0];
                `EEC_OFF_RISE:  rise_en <= wdata[NUM_LINES-1:0];
                `EEC_OFF_FALL:  fall_en <= wdata[NUM_LINES-1:0];
                default: ;
            endcase
        end
    end

    // pin select registers
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            for (int i = 0; i < NUM_EXT; i++) begin
                sel[i] <= SEL_W'(`EEC_RST_SEL);
            end
        end else if (wr && is_sel(addr)) begin
            sel[sel_idx(addr)] <= wdata[SEL_W-1:0]; // RULE_06
        end
    end

    // event requests: one pulse per qualified edge, own mask
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b)
            evt_pulse <= '0;
        else
            evt_pulse <= trig & emask; // RULE_03
    end

    // interrupt level: each line gated only by its own mask bit
    assign masked_any = |(pending & imask);

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b)
            irq <= 1'b0;
        else
            irq <= masked_any; // RULE_03
    end

    // read mux; unmapped offsets read zero
    assign pend_word = 32'(pending);

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (is_sel(addr)) begin
            rd_mux = 32'(sel[sel_idx(addr)]);
        end else begin
            case (addr)
                `EEC_OFF_IMASK: rd_mux = 32'(imask);
                `EEC_OFF_EMASK: rd_mux = 32'(emask);
                `EEC_OFF_RISE:  rd_mux = 32'(rise_en);
                `EEC_OFF_FALL:  rd_mux = 32'(fall_en);
                `EEC_OFF_PEND:  rd_mux = pend_word; // RULE_04
                default:        rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // data only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b)
            rdata <= 32'h0000_0000;
        else
            rdata <= rd ? rd_mux : 32'h0000_0000;
    end

    a_pend_set: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE_04
        (|trig) |=> ((pending & $past(trig)) == $past(trig)))
        else $error("qualified edge did not set pending");

    a_pend_hold: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE_07
        ((~pending & $past(pending) & ~$past(clr_vec)) == '0))
        else $error("pending dropped without a clear write");

    a_irq_level: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE_03
        ##1 (irq == $past(masked_any)))
        else $error("irq does not follow masked pending");

    a_evt_masked: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE_03
        ((evt_pulse & ~($past(trig) & $past(emask))) == '0))
        else $error("event pulse without unmasked trigger");

    // watched on the first on-chip line, whose level changes are slow enough to sample
    a_rise_catch: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE_02
        ($rose(lif.line[NUM_EXT]) && rise_en[NUM_EXT] && $stable(rise_en)) |-> ##[1:DET_MAX] pending[NUM_EXT])
        else $error("rising edge on first on-chip line not caught");

    a_fall_catch: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE_02
        ($fell(lif.line[NUM_EXT]) && fall_en[NUM_EXT] && $stable(fall_en)) |-> ##[1:DET_MAX] pending[NUM_EXT])
        else $error("falling edge on first on-chip line not caught");

    a_evt_follow: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE_01
        (|(trig & emask)) |=> (evt_pulse == $past(trig & emask)))
        else $error("unmasked trigger gave no event pulse");

    a_rd_idle: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE_04
        (!rd) |=> (rdata == 32'h0000_0000))
        else $error("read data outside the cycle after a read");

    a_pend_read: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE_04
        (rd && addr == `EEC_OFF_PEND) |=> (rdata == $past(pend_word)))
        else $error("pending read returned wrong value");

endmodule

`default_nettype wire

// [tb/eec_line_model.sv]
`default_nettype none

// pin and source levels; edges land between clock edges on purpose
module eec_line_model (
    // levels toward the block
    output var logic [139:0] gpio_in,
    output var logic [6:0]   int_line
);
    timeunit 1ns;
    timeprecision 1ns;

    // all lines start low
    initial begin
        gpio_in  = '0;
        int_line = '0;
    end

    // one on-chip source level
    task automatic set_src(input int i, input logic v);
        #30; // off the sampling edge, no race with the sync flops
        int_line[i] = v;
    endtask

    // pulse shorter than a period, only an async catcher sees it
    task automatic blip_pin(input int p, input int ns);
        #30; // whole pulse sits between two clock edges
        gpio_in[p] = 1'b1;
        #(ns);
        gpio_in[p] = 1'b0;
    endtask
endmodule

`default_nettype wire

// [tb/tb_top.sv]
`include "eec_params.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import eec_pkg::*;

    logic          clk;
    logic          rst_b;
    eec_addr_t     addr;
    eec_word_t     wdata;
    logic          wr;
    logic          rd;
    eec_word_t     rdata;
    logic          irq;
    logic [22:0]   evt_pulse;
    logic [139:0]  gpio_in;
    logic [6:0]    int_line;
    int            err_count;
    int            checks_done;
    int            cyc = 0;
    int            evt_cnt = 0;
    int            evt_other = 0;
    logic [31:0]   exp_sel [4] = '{32'h8001, 32'h1, 32'h8000, 32'h8001};

    eec_top eec_top_i (.clk(clk), .rst_b(rst_b), .gpio_in(gpio_in), .int_line(int_line), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .evt_pulse(evt_pulse));
    eec_line_model eec_line_model_i (.gpio_in(gpio_in), .int_line(int_line));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // event counter on line 16 plus a hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (evt_pulse[16] === 1'b1) evt_cnt <= evt_cnt + 1;
        // only line 16 is ever event-unmasked, any other pulse is wrong
        if ((evt_pulse & ~23'h01_0000) !== 23'h00_0000) evt_other <= evt_other + 1;
        if (cyc == 3000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input eec_addr_t a, input eec_word_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd_chk(input eec_addr_t a, input eec_word_t exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask

    // ends off the edge so flags have settled
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        err_count = 0;
        checks_done = 0;
        rst_b = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values, unmapped place, width of a line register
        for (int k = 0; k < 5; k++) rd_chk(8'(4 * k), 32'h0);
        rd_chk(`EEC_OFF_SEL_BASE, 32'h0);
        wr_reg(8'h3c, 32'hffff_ffff);
        rd_chk(8'h3c, 32'h0);
        wr_reg(`EEC_OFF_RISE, 32'hffff_ffff);
        rd_chk(`EEC_OFF_RISE, 32'h007f_ffff);
        $display("test done: registers");
        // every edge choice on line 16, both directions
        for (int m = 0; m < 4; m++) begin
            wr_reg(`EEC_OFF_RISE, {15'h0, m[0], 16'h0});
            wr_reg(`EEC_OFF_FALL, {15'h0, m[1], 16'h0});
            eec_line_model_i.set_src(0, 1'b1);
            cyc_wait(6);
            rd_chk(`EEC_OFF_PEND, {15'h0, m[0], 16'h0});
            wr_reg(`EEC_OFF_PEND, 32'h0001_0000);
            eec_line_model_i.set_src(0, 1'b0);
            cyc_wait(6);
            rd_chk(`EEC_OFF_PEND, {15'h0, m[1], 16'h0});
            wr_reg(`EEC_OFF_PEND, 32'h0001_0000);
        end
        $display("test done: edge modes");
        // lines 0 to 15 unmasked only: pending kept, no interrupt
        wr_reg(`EEC_OFF_IMASK, 32'h0000_ffff);
        wr_reg(`EEC_OFF_EMASK, 32'h0001_0000);
        eec_line_model_i.set_src(0, 1'b1);
        cyc_wait(6);
        rd_chk(`EEC_OFF_PEND, 32'h0001_0000);
        chk({31'h0, irq}, 32'h0);
        chk(32'(evt_cnt), 32'h1);
        wr_reg(`EEC_OFF_IMASK, 32'h0001_0000);
        cyc_wait(2);
        chk({31'h0, irq}, 32'h1);
        cyc_wait(4);
        chk({31'h0, irq}, 32'h1);
        wr_reg(`EEC_OFF_PEND, 32'h0001_0000);
        cyc_wait(2);
        chk({31'h0, irq}, 32'h0);
        rd_chk(`EEC_OFF_PEND, 32'h0);
        $display("test done: masks");
        // short pin pulses through the selects, one pin shared by two lines
        wr_reg(`EEC_OFF_RISE, 32'h0000_8001);
        wr_reg(`EEC_OFF_FALL, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr_reg(8'(`EEC_OFF_SEL_BASE + 60 * (k / 2)), 32'(139 * (k % 2)));
            wr_reg(`EEC_OFF_PEND, 32'h007f_ffff);
            eec_line_model_i.blip_pin(139 * (k % 2), 20);
            cyc_wait(6);
            rd_chk(`EEC_OFF_PEND, exp_sel[k]);
        end
        rd_chk(8'(`EEC_OFF_SEL_BASE + 60), 32'h0000_008b);
        chk(32'(evt_other), 32'h0);
        $display("test done: pin select");
        tally_and_finish();
    end
endmodule

`default_nettype wire
